// ---- vic_pkg.sv ----
/*
 * Shared constants for the vectored interrupt controller: source map, register
 * offsets, field positions and reset values.
 * Assumes a 12-bit APB byte address and 32-bit data.
 */
package vic_pkg;
    localparam int          NSRC         = 19;
    localparam int          PRIO_W       = 3;
    localparam int          ID_W         = 5;
    localparam int          STACK_DEPTH  = 8;
    localparam int          STACK_PTR_W  = 4;
    localparam logic [31:0] SRC_MASK     = 32'h0007_01ff;
    localparam logic [31:0] NORMAL_MASK  = 32'h0007_01fe;
    localparam logic [31:0] VEC_RESET    = 32'h0000_0000;
    localparam logic [31:0] SPUR_RESET   = 32'h0000_0000;
    localparam int          MODE_EDGE_BIT = 5;
    localparam int          CORE_REQ_BIT  = 1;
    localparam logic [11:0] MODE_BASE    = 12'h000;
    localparam logic [11:0] VEC_BASE     = 12'h080;
    localparam logic [11:0] VEC_READ     = 12'h100;
    localparam logic [11:0] CUR_ID       = 12'h104;
    localparam logic [11:0] PEND_FLAGS   = 12'h10c;
    localparam logic [11:0] ENABLED      = 12'h110;
    localparam logic [11:0] CORE_STATUS  = 12'h114;
    localparam logic [11:0] ENABLE_CMD   = 12'h120;
    localparam logic [11:0] DISABLE_CMD  = 12'h124;
    localparam logic [11:0] CLEAR_CMD    = 12'h128;
    localparam logic [11:0] SET_CMD      = 12'h12c;
    localparam logic [11:0] EOS_CMD      = 12'h130;
    localparam logic [11:0] SPUR_ADDR    = 12'h134;

    typedef enum logic [3:0] {
        RK_NONE, RK_MODE, RK_VEC, RK_IVR, RK_CURID, RK_PEND, RK_ENA,
        RK_CORE, RK_ENCMD, RK_DISCMD, RK_CLR, RK_SET, RK_EOS, RK_SPUR
    } reg_kind_type;
endpackage : vic_pkg

// ---- stack_if.sv ----
/*
 * Interface between the controller core and its priority level stack.
 * Assumes one clock domain; the stack registers on the controller clock.
 */
`timescale 1ns/1ps
interface stack_if;
    import vic_pkg::*;
    logic                   push;
    logic                   pop;
    logic [PRIO_W-1:0]      push_level;
    logic [PRIO_W-1:0]      top_level;
    logic                   has_level;
    logic [STACK_PTR_W-1:0] depth;
    modport ctl (output push, pop, push_level, input top_level, has_level, depth);
    modport stk (input push, pop, push_level, output top_level, has_level, depth);
endinterface : stack_if

// ---- prio_select.sv ----
/*
 * Combinational selector of the highest-priority candidate source.
 * Assumes candidates are already masked by pending and enable state.
 */
`timescale 1ns/1ps
module prio_select
    import vic_pkg::*;
#(
    parameter int N = NSRC,
    parameter int W = PRIO_W
) (
    input  wire logic [N-1:0]   cand,
    input  wire logic [N*W-1:0] prio_flat,
    output logic                found,
    output logic [ID_W-1:0]     id,
    output logic [W-1:0]        prio
);
    // Scanning downward with >= leaves the lowest index among equals.
    always_comb begin
        found = 1'b0;
        id    = '0;
        prio  = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (cand[i] && (!found || prio_flat[i*W +: W] >= prio)) begin
                found = 1'b1;
                id    = ID_W'(i);
                prio  = prio_flat[i*W +: W];
            end
        end
    end
endmodule : prio_select

// ---- level_stack.sv ----
/*
 * Hardware stack of current priority levels for nested service.
 * Assumes push and pop never arrive in the same cycle.
 */
`timescale 1ns/1ps
module level_stack
    import vic_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH
) (
    input  wire logic pclk,
    input  wire logic presetn,
    stack_if.stk      stk
);
    logic [PRIO_W-1:0]      mem_q [DEPTH];
    logic [PRIO_W-1:0]      mem_d [DEPTH];
    logic [STACK_PTR_W-1:0] ptr_q;
    logic [STACK_PTR_W-1:0] ptr_d;

    // A full stack ignores a push; strictly rising levels cannot overflow it.
    always_comb begin
        mem_d = mem_q;
        ptr_d = ptr_q;
        if (stk.push && ptr_q < STACK_PTR_W'(DEPTH)) begin
            mem_d[ptr_q[STACK_PTR_W-2:0]] = stk.push_level;
            ptr_d = ptr_q + 1'b1;
        end else if (stk.pop && ptr_q != '0) begin
            ptr_d = ptr_q - 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptr_q <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else begin
            ptr_q <= ptr_d;
            mem_q <= mem_d;
        end
    end

    logic [STACK_PTR_W-1:0] top_idx;
    assign top_idx       = ptr_q - 1'b1;
    assign stk.has_level = (ptr_q != '0);
    assign stk.top_level = mem_q[top_idx[STACK_PTR_W-2:0]];
    assign stk.depth     = ptr_q;

    a_pop_depth: assert property (@(posedge pclk) disable iff (!presetn)
        stk.pop && ptr_q != '0 |=> ptr_q == $past(ptr_q) - 1'b1)
        else $error("pop did not lower the stack depth by one");
    a_push_top: assert property (@(posedge pclk) disable iff (!presetn)
        stk.push && ptr_q < STACK_PTR_W'(DEPTH) |=> stk.top_level == $past(stk.push_level))
        else $error("pushed level is not on top of the stack");
endmodule : level_stack

// ---- vectored_irq_priority_control.sv ----
/*
 * Vectored priority interrupt controller with APB register access, command
 * registers, vector read with level stacking and end-of-service popping.
 * Assumes an APB master on pclk; peripheral requests are on pclk, the three
 * external requests arrive asynchronously on pins.
 */
// The APB register port was decided locally.
// Functional notes
// - Clear command ones clear matching pending sources; zeros do nothing.
// - Set command ones force matching sources pending; zeros do nothing.
// - Source bits: fast 0, software 1, serial/timer/watchdog 2-7, pio 8, external 16-18.
// - Any write to end-of-service command signals completion, data ignored.
// - A 32-bit writable register holds the spurious handler address.
// - Vector read makes the best pending source current, at its level.
// - Vector read drops the core request line.
// - Vector read clears pending of an edge-triggered selected source.
// - Vector read pushes the new current level onto the stack.
// - Vector read returns the stored vector of the selected source.
// - Request line rises again for pending priority above the current level.
// - End-of-service pops the stack, restoring the previous level.
// - After the pop, request rises for pending above the restored level.
// - Pending register reads one for pending, zero for inactive sources.
// - Enable command ones enable sources; only enabled sources compete.
`timescale 1ns/1ps
module vectored_irq_priority_control
    import vic_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [8:0]  periph_req,
    input  wire logic [2:0]  ext_req_pin,
    output logic             core_request_line_n
);
    logic [31:0]       pend_q;
    logic [31:0]       pend_d;
    logic [31:0]       enab_q;
    logic [31:0]       enab_d;
    logic [31:0]       edge_q;
    logic [31:0]       edge_d;
    logic [31:0]       reqd_q;
    logic [31:0]       reqd_d;
    logic [PRIO_W-1:0] prio_q [NSRC];
    logic [PRIO_W-1:0] prio_d [NSRC];
    logic [31:0]       vec_q  [NSRC];
    logic [31:0]       vec_d  [NSRC];
    logic [31:0]       spur_q;
    logic [31:0]       spur_d;
    logic [ID_W-1:0]   cur_id_q;
    logic [ID_W-1:0]   cur_id_d;
    logic [2:0]        s1_q;
    logic [2:0]        s2_q;
    logic [2:0]        s3_q;
    logic [2:0]        ext_q;
    logic [2:0]        ext_d;
    logic [31:0]       prdata_q;
    logic [31:0]       prdata_d;
    logic              pready_q;
    logic              pready_d;
    logic              pslverr_q;
    logic              pslverr_d;
    logic              lat_found_q;
    logic              lat_found_d;
    logic [ID_W-1:0]   lat_id_q;
    logic [ID_W-1:0]   lat_id_d;
    logic [PRIO_W-1:0] lat_prio_q;
    logic [PRIO_W-1:0] lat_prio_d;
    logic              req_n_q;
    logic              req_n_d;

    stack_if stk ();

    function automatic reg_kind_type decode(input logic [11:0] a);
        logic [ID_W-1:0] i;
        i = a[6:2];
        decode = RK_NONE;
        if (a[1:0] != 2'b00) begin
            decode = RK_NONE;
        end else if (a[11:7] == MODE_BASE[11:7] && i < ID_W'(NSRC) && SRC_MASK[i]) begin
            decode = RK_MODE;
        end else if (a[11:7] == VEC_BASE[11:7] && i < ID_W'(NSRC) && SRC_MASK[i]) begin
            decode = RK_VEC;
        end else begin
            case (a)
                VEC_READ:    decode = RK_IVR;
                CUR_ID:      decode = RK_CURID;
                PEND_FLAGS:  decode = RK_PEND;
                ENABLED:     decode = RK_ENA;
                CORE_STATUS: decode = RK_CORE;
                ENABLE_CMD:  decode = RK_ENCMD;
                DISABLE_CMD: decode = RK_DISCMD;
                CLEAR_CMD:   decode = RK_CLR;
                SET_CMD:     decode = RK_SET;
                EOS_CMD:     decode = RK_EOS;
                SPUR_ADDR:   decode = RK_SPUR;
                default:     decode = RK_NONE;
            endcase
        end
    endfunction : decode

    reg_kind_type      kind;
    logic [ID_W-1:0]   idx;
    logic              setup;
    logic              access;
    logic              wr_any;
    logic              wr_clr;
    logic              wr_set;
    logic              wr_en;
    logic              wr_eos;
    logic              ivr_take;
    logic [31:0]       raw_req;
    logic [31:0]       eff_pend;
    logic [31:0]       cand;
    logic [31:0]       set_ev;
    logic [NSRC*PRIO_W-1:0] prio_flat;
    logic              sel_found;
    logic [ID_W-1:0]   sel_id;
    logic [PRIO_W-1:0] sel_prio;
    logic              above;

    assign kind     = decode(paddr);
    assign idx      = paddr[6:2];
    assign setup    = psel && !penable;
    assign access   = psel && penable && pready_q;
    assign wr_any   = access && pwrite;
    assign wr_clr   = wr_any && kind == RK_CLR;
    assign wr_set   = wr_any && kind == RK_SET;
    assign wr_en    = wr_any && kind == RK_ENCMD;
    assign wr_eos   = wr_any && kind == RK_EOS;
    assign ivr_take = access && !pwrite && kind == RK_IVR;

    // External pins pass three flops; the level moves only when the last two agree.
    assign raw_req  = {13'h0, ext_q, 7'h0, periph_req};
    // A level-sensitive source counts as pending while its request is high.
    assign eff_pend = (pend_q | (~edge_q & raw_req)) & SRC_MASK;
    assign cand     = eff_pend & enab_q & NORMAL_MASK;

    generate
        for (genvar g = 0; g < NSRC; g++) begin : g_flat
            assign prio_flat[g*PRIO_W +: PRIO_W] = prio_q[g];
        end
    endgenerate

    prio_select #(
        .N (NSRC),
        .W (PRIO_W)
    ) u_select (
        .cand      (cand[NSRC-1:0]),
        .prio_flat (prio_flat),
        .found     (sel_found),
        .id        (sel_id),
        .prio      (sel_prio)
    );

    // Only strictly higher priority than the current level may interrupt.
    assign above = sel_found && (!stk.has_level || sel_prio > stk.top_level);

    level_stack #(
        .DEPTH (STACK_DEPTH)
    ) u_stack (
        .pclk    (pclk),
        .presetn (presetn),
        .stk     (stk)
    );

    assign stk.push       = ivr_take && lat_found_q;
    assign stk.pop        = wr_eos;
    assign stk.push_level = lat_prio_q;

    always_comb begin
        logic [31:0] clr_ev;
        logic [31:0] rd;
        clr_ev   = '0;
        rd       = '0;
        ext_d    = (s2_q == s3_q) ? s3_q : ext_q;
        reqd_d   = raw_req;
        set_ev   = raw_req & ~reqd_q & edge_q;
        enab_d   = enab_q;
        edge_d   = edge_q;
        prio_d   = prio_q;
        vec_d    = vec_q;
        spur_d   = spur_q;
        cur_id_d = cur_id_q;
        if (wr_set) begin
            set_ev = set_ev | (pwdata & SRC_MASK);
        end
        if (wr_clr) begin
            clr_ev = pwdata & SRC_MASK;
        end
        if (ivr_take && lat_found_q) begin
            cur_id_d = lat_id_q;
            if (edge_q[lat_id_q]) begin
                clr_ev[lat_id_q] = 1'b1;
            end
        end
        // A new event in the clearing cycle survives the clear.
        pend_d = (set_ev | (pend_q & ~clr_ev)) & SRC_MASK;
        if (wr_en) begin
            enab_d = enab_q | (pwdata & SRC_MASK);
        end
        if (wr_any && kind == RK_DISCMD) begin
            enab_d = enab_q & ~pwdata;
        end
        if (wr_any && kind == RK_MODE) begin
            prio_d[idx] = pwdata[PRIO_W-1:0];
            edge_d[idx] = pwdata[MODE_EDGE_BIT];
        end
        if (wr_any && kind == RK_VEC) begin
            vec_d[idx] = pwdata;
        end
        if (wr_any && kind == RK_SPUR) begin
            spur_d = pwdata;
        end

        // Read data and the vector selection are frozen at setup, so the
        // access edge acts on exactly what the master is handed.
        case (kind)
            RK_MODE: begin
                rd[PRIO_W-1:0]    = prio_q[idx];
                rd[MODE_EDGE_BIT] = edge_q[idx];
            end
            RK_VEC:   rd = vec_q[idx];
            RK_IVR:   rd = above ? vec_q[sel_id] : spur_q;
            RK_CURID: rd[ID_W-1:0] = cur_id_q;
            RK_PEND:  rd = eff_pend;
            RK_ENA:   rd = enab_q;
            RK_CORE:  rd[CORE_REQ_BIT] = !req_n_q;
            RK_SPUR:  rd = spur_q;
            default:  rd = '0;
        endcase
        prdata_d    = prdata_q;
        pready_d    = pready_q;
        pslverr_d   = pslverr_q;
        lat_found_d = lat_found_q;
        lat_id_d    = lat_id_q;
        lat_prio_d  = lat_prio_q;
        if (setup) begin
            prdata_d    = pwrite ? 32'h0 : rd;
            pready_d    = 1'b1;
            pslverr_d   = (kind == RK_NONE);
            lat_found_d = above;
            lat_id_d    = sel_id;
            lat_prio_d  = sel_prio;
        end else if (access) begin
            pready_d  = 1'b0;
            pslverr_d = 1'b0;
        end
        // The line drops once no enabled pending source is above the current level, as after a read.
        req_n_d = !above;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q      <= '0;
            enab_q      <= '0;
            edge_q      <= '0;
            reqd_q      <= '0;
            spur_q      <= SPUR_RESET;
            cur_id_q    <= '0;
            s1_q        <= '0;
            s2_q        <= '0;
            s3_q        <= '0;
            ext_q       <= '0;
            prdata_q    <= '0;
            pready_q    <= 1'b0;
            pslverr_q   <= 1'b0;
            lat_found_q <= 1'b0;
            lat_id_q    <= '0;
            lat_prio_q  <= '0;
            req_n_q     <= 1'b1;
            for (int i = 0; i < NSRC; i++) begin
                prio_q[i] <= '0;
                vec_q[i]  <= VEC_RESET;
            end
        end else begin
            pend_q      <= pend_d;
            enab_q      <= enab_d;
            edge_q      <= edge_d;
            reqd_q      <= reqd_d;
            spur_q      <= spur_d;
            cur_id_q    <= cur_id_d;
            s1_q        <= ext_req_pin;
            s2_q        <= s1_q;
            s3_q        <= s2_q;
            ext_q       <= ext_d;
            prdata_q    <= prdata_d;
            pready_q    <= pready_d;
            pslverr_q   <= pslverr_d;
            lat_found_q <= lat_found_d;
            lat_id_q    <= lat_id_d;
            lat_prio_q  <= lat_prio_d;
            req_n_q     <= req_n_d;
            prio_q      <= prio_d;
            vec_q       <= vec_d;
        end
    end

    assign prdata              = prdata_q;
    assign pready              = pready_q;
    assign pslverr             = pslverr_q;
    assign core_request_line_n = req_n_q;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_take_found;
        ivr_take && lat_found_q;
    endsequence
    sequence s_line_free;
        ##1 !above;
    endsequence

    a_clear_cmd: assert property (wr_clr |=> (pend_q & $past(pwdata) & ~$past(set_ev)) == 32'h0)
        else $error("clear command left a source pending");
    a_set_cmd: assert property (wr_set |=> (pend_q & $past(pwdata & SRC_MASK)) == $past(pwdata & SRC_MASK))
        else $error("set command did not make sources pending");
    a_map_bits: assert property ((pend_q & ~SRC_MASK) == 32'h0 && (eff_pend & ~SRC_MASK) == 32'h0)
        else $error("pending state outside the source map");
    a_eos_pop: assert property (wr_eos && stk.has_level |=> stk.depth == $past(stk.depth) - 1'b1)
        else $error("end-of-service write did not pop the stack");
    a_spur_write: assert property (wr_any && kind == RK_SPUR |=> spur_q == $past(pwdata))
        else $error("spurious address not stored");
    a_take_level: assert property (s_take_found |=> stk.top_level == $past(lat_prio_q)
        && cur_id_q == $past(lat_id_q))
        else $error("vector read did not set current source and level");
    a_take_drops: assert property (s_take_found ##0 s_line_free |=> core_request_line_n)
        else $error("request line stayed active after vector read");
    a_edge_clear: assert property (s_take_found and (edge_q[lat_id_q] && !set_ev[lat_id_q])
        |=> !pend_q[$past(lat_id_q)])
        else $error("edge source still pending after vector read");
    a_vec_data: assert property (ivr_take |-> prdata == (lat_found_q ? vec_q[lat_id_q] : spur_q))
        else $error("vector read returned the wrong value");
    a_nest_req: assert property (above |=> !core_request_line_n)
        else $error("higher pending source did not raise the request line");
    a_pend_read: assert property (setup && !pwrite && kind == RK_PEND |=> prdata == $past(eff_pend))
        else $error("pending register read mismatch");
    a_enable_cmd: assert property (wr_en |=> (enab_q & $past(pwdata & SRC_MASK)) == $past(pwdata & SRC_MASK))
        else $error("enable command did not enable sources");
    a_spur_keep: assert property (ivr_take && !lat_found_q |=> stk.depth == $past(stk.depth))
        else $error("spurious vector read changed the stack");
endmodule : vectored_irq_priority_control

// ---- core_model.sv ----
/* Model of the processor core on the normal request line.
   Assumes the bench sets the mask bit as the handler would. */
`timescale 1ns/1ps
module core_model (
    input  wire logic core_request_line_n,
    input  wire logic irq_mask,
    output logic      take
);
    // The core jumps to 0x18 only while the line is low and unmasked.
    assign take = !core_request_line_n && !irq_mask;
endmodule : core_model

// ---- vectored_irq_priority_control_test.sv ----
/* Self-checking bench for the vectored interrupt controller.
   Assumes the core model beside it and an APB master on one clock. */
`timescale 1ns/1ps
module vectored_irq_priority_control_test;
    import vic_pkg::*;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic        pready;
    logic        pslverr;
    logic        line_n;
    logic        irq_mask;
    logic        err;
    logic        take;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic [31:0] rv;
    logic [8:0]  periph_req;
    logic [2:0]  ext_req_pin;
    int          num_errors = 0;
    int          cmp_count = 0;

    vectored_irq_priority_control dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .periph_req(periph_req), .ext_req_pin(ext_req_pin), .core_request_line_n(line_n));
    core_model u_core (.core_request_line_n(line_n), .irq_mask(irq_mask), .take(take));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic end_sim;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // The request is held until pready is seen high; an idle edge follows so calls never collide.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees pready.
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rv  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rdc(input string name, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(name, exp, rv);
    endtask : rdc

    task automatic line_is(input logic v);
        repeat (2) @(posedge pclk);
        chk("request_line_n", {31'h0, v}, {31'h0, line_n});
    endtask : line_is

    task automatic wait_low;
        int n;
        n = 0;
        while (line_n !== 1'b0 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        chk("request_line_n", 32'h0, {31'h0, line_n});
    endtask : wait_low

    task automatic t_setclr;
        apb(1'b1, SET_CMD, 32'hffff_ffff);
        rdc("pending", PEND_FLAGS, SRC_MASK);
        line_is(1'b1);
        apb(1'b1, CLEAR_CMD, 32'h0000_0004);
        rdc("pending", PEND_FLAGS, 32'h0007_01fb);
        apb(1'b1, CLEAR_CMD, 32'hffff_ffff);
        rdc("pending", PEND_FLAGS, 32'h0);
    endtask : t_setclr

    task automatic t_spur;
        rdc("spurious", SPUR_ADDR, SPUR_RESET);
        apb(1'b1, SPUR_ADDR, 32'h1234_5678);
        rdc("spurious", SPUR_ADDR, 32'h1234_5678);
        rdc("vector", VEC_READ, 32'h1234_5678);
        rdc("current_id", CUR_ID, 32'h0);
    endtask : t_spur

    task automatic t_nest;
        for (int i = 2; i < 5; i++) begin
            apb(1'b1, MODE_BASE + 12'(4 * i), (i == 4) ? 32'h26 : 32'h23);
            apb(1'b1, VEC_BASE + 12'(4 * i), 32'h100 + i);
        end
        apb(1'b1, ENABLE_CMD, 32'h0000_001c);
        rdc("enabled", ENABLED, 32'h0000_001c);
        apb(1'b1, SET_CMD, 32'h0000_000c);
        wait_low();
        chk("take", 32'h1, {31'h0, take});
        rdc("core_status", CORE_STATUS, 32'h0000_0002);
        irq_mask <= 1'b1;
        rdc("vector", VEC_READ, 32'h102);
        rdc("current_id", CUR_ID, 32'h2);
        rdc("pending", PEND_FLAGS, 32'h8);
        line_is(1'b1);
        apb(1'b1, SET_CMD, 32'h0000_0010);
        wait_low();
        rdc("vector", VEC_READ, 32'h104);
        rdc("current_id", CUR_ID, 32'h4);
        apb(1'b1, EOS_CMD, 32'hffff_ffff);
        line_is(1'b1);
        apb(1'b1, EOS_CMD, 32'h0);
        wait_low();
        rdc("vector", VEC_READ, 32'h103);
        apb(1'b1, EOS_CMD, 32'h5a5a_0001);
        rdc("pending", PEND_FLAGS, 32'h0);
        irq_mask <= 1'b0;
    endtask : t_nest

    task automatic t_level;
        apb(1'b1, MODE_BASE + 12'h020, 32'h02);
        apb(1'b1, VEC_BASE + 12'h020, 32'h108);
        apb(1'b1, ENABLE_CMD, 32'h0000_0100);
        periph_req <= 9'h100;
        wait_low();
        rdc("vector", VEC_READ, 32'h108);
        apb(1'b1, CLEAR_CMD, 32'h0000_0100);
        rdc("pending", PEND_FLAGS, 32'h100);
        periph_req <= 9'h000;
        apb(1'b1, EOS_CMD, 32'h0);
        line_is(1'b1);
        rdc("pending", PEND_FLAGS, 32'h0);
        ext_req_pin <= 3'b001;
        repeat (6) @(posedge pclk);
        rdc("pending", PEND_FLAGS, 32'h0001_0000);
        ext_req_pin <= 3'b000;
        repeat (6) @(posedge pclk);
        rdc("pending", PEND_FLAGS, 32'h0);
        rdc("mode", MODE_BASE + 12'h020, 32'h0000_0002);
        rdc("vector_8", VEC_BASE + 12'h020, 32'h0000_0108);
        apb(1'b1, DISABLE_CMD, 32'h0000_0100);
        rdc("enabled", ENABLED, 32'h0000_001c);
    endtask : t_level

    task automatic t_err;
        apb(1'b1, 12'h200, 32'h1);
        chk("pslverr", 32'h1, {31'h0, err});
        rdc("clear_cmd", CLEAR_CMD, 32'h0);
        chk("pslverr", 32'h0, {31'h0, err});
    endtask : t_err

    initial begin
        presetn     = 1'b0;
        psel        = 1'b0;
        penable     = 1'b0;
        pwrite      = 1'b0;
        paddr       = 12'h000;
        pwdata      = 32'h0;
        irq_mask    = 1'b0;
        periph_req  = 9'h000;
        ext_req_pin = 3'b000;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_setclr();
        t_spur();
        t_nest();
        t_level();
        t_err();
        end_sim();
    end

    // Whole run needs well under two thousand cycles.
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        end_sim();
    end
endmodule : vectored_irq_priority_control_test
